// ==== src/cix_defs.svh ====
`ifndef CIX_DEFS_SVH
`define CIX_DEFS_SVH

// Opcode patterns.
`define CIX_OP_TOGGLE 4'h7
`define CIX_OP_BRANCH 4'he
`define CIX_SUB_OVF 4'h4
`define CIX_SUB_ZERO 4'h0
`define CIX_OP_CALL_HI 7'h76
`define CIX_OP_CALL2 4'hf
`define CIX_OP_CLEAR 7'h35
`define CIX_OP_WDCLR 16'h0004
// Indexed literal offset limit.
`define CIX_ILO_LIMIT 8'h5f
// Return address, branch base and PC step offsets in bytes.
`define CIX_CALL_RET 21'h000004
`define CIX_BRANCH_BASE 21'h000002
`define CIX_PC_STEP 21'h000002
// Status bit positions in the flags vector.
`define CIX_FLAG_ZERO 2
`define CIX_FLAG_OVF 3
// Reset PC and the value written by the clear instruction.
`define CIX_PC_RESET 21'h000000
`define CIX_CLEAR_VALUE 8'h00

`endif

// ==== src/cix_pkg.sv ====
package cix_pkg;
    typedef enum logic [1:0] {CIX_EXEC, CIX_CALL2, CIX_FLUSH} cix_state_t;

    // Data memory access request.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [7:0] wdata;
    } cix_mem_t;

    // Shadow save group.
    typedef struct packed {
        logic save;
        logic [7:0] working;
        logic [7:0] flags;
        logic [7:0] bank;
    } cix_shadow_t;

    // Complete module state.
    typedef struct packed {
        cix_state_t state;
        logic [20:0] pc;
        logic [7:0] call_low;
        logic call_shadow;
        logic [20:0] call_ret;
        cix_mem_t mem;
        logic push;
        logic [20:0] push_addr;
        cix_shadow_t shadow;
        logic set_zero;
        logic wd_clear;
    } cix_regs_t;
endpackage

// ==== src/cix_core.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "cix_defs.svh"

module cix_core
    import cix_pkg::*;
(
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic [15:0] INSTR,
    input wire logic EXT_SET_EN,
    input wire logic [7:0] FSR2_BASE,
    input wire logic [7:0] FLAGS,
    input wire logic [7:0] WORKING,
    input wire logic [3:0] BANK_SELECT_REGISTER,
    input wire logic [7:0] MEM_RDATA,
    output logic [20:0] PC,
    output logic MEM_WR,
    output logic MEM_RD,
    output logic [11:0] MEM_ADDR,
    output logic [7:0] MEM_WDATA,
    output logic PUSH,
    output logic [20:0] RETURN_STACK_TOP,
    output logic SHADOW_SAVE,
    output logic [7:0] WORKING_SHADOW,
    output logic [7:0] FLAGS_SHADOW,
    output logic [7:0] BANK_SELECT_SHADOW,
    output logic SET_ZERO,
    output logic WATCHDOG_CLEAR
);
    cix_regs_t r;
    cix_regs_t next_r;
    logic [11:0] addr;
    logic [7:0] fa;
    logic is_toggle;
    logic is_branch;
    logic taken;
    logic [20:0] offset2;

    // Address formation for file-addressed instructions.
    always_comb begin
        fa = INSTR[7:0];
        if (!INSTR[8] && EXT_SET_EN && fa <= `CIX_ILO_LIMIT) begin
            // Indexed window is based on the pointer supplied to the core on FSR2_BASE.
            addr = {4'h0, FSR2_BASE + fa};
        end else if (!INSTR[8]) begin
            // Access bank: low half low memory, high half special registers.
            addr = fa[7] ? {4'hf, fa} : {4'h0, fa};
        end else begin
            addr = {BANK_SELECT_REGISTER, fa};
        end
    end

    // Branch decode; offset is doubled and sign extended.
    assign is_toggle = INSTR[15:12] == `CIX_OP_TOGGLE;
    assign is_branch = INSTR[15:12] == `CIX_OP_BRANCH
        && (INSTR[11:8] == `CIX_SUB_OVF || INSTR[11:8] == `CIX_SUB_ZERO);
    assign taken = INSTR[11:8] == `CIX_SUB_OVF ? FLAGS[`CIX_FLAG_OVF] : FLAGS[`CIX_FLAG_ZERO];
    assign offset2 = {{12{INSTR[7]}}, INSTR[7:0], 1'b0};

    // Next state. The toggle read uses a combinational memory read port, so
    // the read and write complete within the same instruction cycle.
    always_comb begin
        next_r = r;
        next_r.mem = '0;
        next_r.push = 1'b0;
        next_r.shadow.save = 1'b0;
        next_r.set_zero = 1'b0;
        next_r.wd_clear = 1'b0;
        case (r.state)
            CIX_EXEC: begin
                next_r.pc = r.pc + `CIX_PC_STEP;
                if (is_toggle) begin
                    next_r.mem.rd = 1'b1;
                    next_r.mem.wr = 1'b1;
                    next_r.mem.addr = addr;
                    next_r.mem.wdata = MEM_RDATA ^ (8'h01 << INSTR[11:9]);
                end else if (is_branch) begin
                    if (taken) begin
                        next_r.pc = r.pc + `CIX_BRANCH_BASE + offset2;
                        next_r.state = CIX_FLUSH;
                    end
                end else if (INSTR[15:9] == `CIX_OP_CALL_HI) begin
                    next_r.call_low = INSTR[7:0];
                    next_r.call_shadow = INSTR[8];
                    next_r.call_ret = r.pc + `CIX_CALL_RET;
                    next_r.state = CIX_CALL2;
                end else if (INSTR[15:9] == `CIX_OP_CLEAR) begin
                    next_r.mem.rd = 1'b1;
                    next_r.mem.wr = 1'b1;
                    next_r.mem.addr = addr;
                    next_r.mem.wdata = `CIX_CLEAR_VALUE;
                    next_r.set_zero = 1'b1;
                end else if (INSTR == `CIX_OP_WDCLR) begin
                    next_r.wd_clear = 1'b1;
                end
            end
            CIX_CALL2: begin
                // Second word carries target bits 19 to 8.
                next_r.push = 1'b1;
                next_r.push_addr = r.call_ret;
                next_r.pc = {INSTR[11:0], r.call_low, 1'b0};
                next_r.shadow.save = r.call_shadow;
                if (r.call_shadow) begin
                    next_r.shadow.working = WORKING;
                    next_r.shadow.flags = FLAGS;
                    next_r.shadow.bank = {4'h0, BANK_SELECT_REGISTER};
                end
                // The second word's cycle is the idle cycle, so the target runs next.
                next_r.state = CIX_EXEC;
            end
            CIX_FLUSH: begin
                // The word at the target is only fetched here and runs in the next
                // cycle, so the PC holds; advancing would skip the target.
                next_r.pc = r.pc;
                next_r.state = CIX_EXEC;
            end
            default: begin
                next_r.state = CIX_EXEC;
            end
        endcase
    end

    // State register.
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign PC = r.pc;
    assign MEM_WR = r.mem.wr;
    assign MEM_RD = r.mem.rd;
    assign MEM_ADDR = r.mem.addr;
    assign MEM_WDATA = r.mem.wdata;
    assign PUSH = r.push;
    assign RETURN_STACK_TOP = r.push_addr;
    assign SHADOW_SAVE = r.shadow.save;
    assign WORKING_SHADOW = r.shadow.working;
    assign FLAGS_SHADOW = r.shadow.flags;
    assign BANK_SELECT_SHADOW = r.shadow.bank;
    assign SET_ZERO = r.set_zero;
    assign WATCHDOG_CLEAR = r.wd_clear;

    // Checks watch the registered outputs one or two edges after the decode edge.
    property p_branch_flush;
        @(posedge MCLK) disable iff (!NRST)
        (r.state == CIX_EXEC && is_branch && taken)
            |=> (r.state == CIX_FLUSH) ##1 (r.state == CIX_EXEC);
    endproperty
    a_branch_flush: assert property (p_branch_flush) else $error("taken branch not two cycles");

    property p_flush_hold;
        @(posedge MCLK) disable iff (!NRST)
        (r.state == CIX_FLUSH) |=> $stable(PC);
    endproperty
    a_flush_hold: assert property (p_flush_hold) else $error("flush moved the PC");

    property p_branch_target;
        @(posedge MCLK) disable iff (!NRST)
        (r.state == CIX_EXEC && is_branch && taken)
            |=> (PC == $past(r.pc) + 21'h2 + $past(offset2));
    endproperty
    a_branch_target: assert property (p_branch_target) else $error("bad branch target");

    property p_not_taken;
        @(posedge MCLK) disable iff (!NRST)
        (r.state == CIX_EXEC && is_branch && !taken)
            |=> (r.state == CIX_EXEC && PC == $past(r.pc) + 21'h2);
    endproperty
    a_not_taken: assert property (p_not_taken) else $error("untaken branch misbehaved");

    property p_branch_quiet;
        @(posedge MCLK) disable iff (!NRST)
        (r.state == CIX_EXEC && is_branch)
            |=> !SET_ZERO && !MEM_WR && !MEM_RD && !PUSH && !WATCHDOG_CLEAR;
    endproperty
    a_branch_quiet: assert property (p_branch_quiet) else $error("branch touched state");

    property p_call_push;
        @(posedge MCLK) disable iff (!NRST)
        (r.state == CIX_EXEC && INSTR[15:9] == 7'h76)
            |=> ##1 (PUSH && RETURN_STACK_TOP == $past(r.pc, 2) + 21'h4);
    endproperty
    a_call_push: assert property (p_call_push) else $error("call push wrong");

    property p_call_cycles;
        @(posedge MCLK) disable iff (!NRST)
        (r.state == CIX_EXEC && INSTR[15:9] == 7'h76)
            |=> (r.state == CIX_CALL2) ##1 (r.state == CIX_EXEC);
    endproperty
    a_call_cycles: assert property (p_call_cycles) else $error("call not two cycles");

    property p_call_shadow;
        @(posedge MCLK) disable iff (!NRST)
        (r.state == CIX_CALL2 && !r.call_shadow)
            |=> !SHADOW_SAVE && $stable(WORKING_SHADOW) && $stable(FLAGS_SHADOW)
            && $stable(BANK_SELECT_SHADOW);
    endproperty
    a_call_shadow: assert property (p_call_shadow) else $error("shadow changed");

    property p_clear;
        @(posedge MCLK) disable iff (!NRST)
        (r.state == CIX_EXEC && INSTR[15:9] == 7'h35)
            |=> (MEM_WR && MEM_WDATA == 8'h00 && SET_ZERO);
    endproperty
    a_clear: assert property (p_clear) else $error("clear wrong");

    property p_wdclr;
        @(posedge MCLK) disable iff (!NRST)
        WATCHDOG_CLEAR |-> !MEM_RD && !MEM_WR && $past(INSTR) == 16'h0004;
    endproperty
    a_wdclr: assert property (p_wdclr) else $error("watchdog clear bad");

    property p_toggle_flags;
        @(posedge MCLK) disable iff (!NRST)
        (r.state == CIX_EXEC && is_toggle)
            |=> MEM_WR && !SET_ZERO && $onehot(MEM_WDATA ^ $past(MEM_RDATA));
    endproperty
    a_toggle_flags: assert property (p_toggle_flags) else $error("toggle bad");
endmodule // cix_core
`default_nettype wire

// ==== verification/cix_prog_mem.sv ====
`timescale 1ns/10ps
`default_nettype none

// Program memory holding the fixed test program; words come out with no latency.
module cix_prog_mem
    import cix_pkg::*;
(
    input wire logic [20:0] pc,
    output logic [15:0] instr
);
    // Words are two bytes wide, so byte address bit 0 is ignored.
    // Words 6 and 7 hold watchdog clears so a wrong fall-through shows up.
    always_comb begin
        case (pc[20:1])
            20'h00000: instr = 16'h7923;
            20'h00001: instr = 16'h6a90;
            20'h00002: instr = 16'h7005;
            20'h00003: instr = 16'h0004;
            20'h00004: instr = 16'he405;
            20'h00005: instr = 16'he002;
            20'h00006: instr = 16'h0004;
            20'h00007: instr = 16'h0004;
            20'h00008: instr = 16'hed20;
            20'h00009: instr = 16'hf000;
            20'h00020: instr = 16'he47f;
            20'h000a0: instr = 16'hec00;
            20'h000a1: instr = 16'hf000;
            default: instr = 16'h0000;
        endcase
    end
endmodule // cix_prog_mem

`default_nettype wire

// ==== verification/core_instr_exec_subset_test.sv ====
`timescale 1ns/10ps
`default_nettype none

module core_instr_exec_subset_test
    import cix_pkg::*;
;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [15:0] instr;
    logic [7:0] flags = 8'h04;
    logic [7:0] working = 8'h3c;
    logic ext_set_en = 1'b1;
    logic [20:0] pc, return_stack_top;
    logic mem_wr, mem_rd, push, shadow_save, set_zero, wd_clear;
    logic [11:0] mem_addr;
    logic [7:0] mem_wdata, w_sh, f_sh, b_sh;
    int num_errors = 0;
    int samples_checked = 0;

    // Free-running instruction clock.
    always #25 mclk = ~mclk;

    cix_prog_mem PROG (.pc(pc), .instr(instr));

    // Read data, bank and index base stay fixed so every address is predictable;
    // the extended-set enable is switched off late in the run.
    cix_core DUT (.MCLK(mclk), .NRST(nrst), .INSTR(instr), .EXT_SET_EN(ext_set_en),
        .FSR2_BASE(8'h10), .FLAGS(flags), .WORKING(working),
        .BANK_SELECT_REGISTER(4'h2), .MEM_RDATA(8'h75), .PC(pc), .MEM_WR(mem_wr),
        .MEM_RD(mem_rd), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .PUSH(push),
        .RETURN_STACK_TOP(return_stack_top), .SHADOW_SAVE(shadow_save), .WORKING_SHADOW(w_sh),
        .FLAGS_SHADOW(f_sh), .BANK_SELECT_SHADOW(b_sh), .SET_ZERO(set_zero),
        .WATCHDOG_CLEAR(wd_clear));

    task automatic chk(input string what, input logic [20:0] exp, input logic [20:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Outputs are looked at just after the edge, once its updates have landed.
    task automatic step;
        @(posedge mclk);
        #1;
    endtask

    task automatic test_done;
        $display("checked %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Guards against a hang; the program needs fewer than 40 cycles.
    initial begin
        repeat (1000) @(posedge mclk);
        num_errors++;
        test_done();
    end

    // Two passes through the stored program, the second ending after the branches; the first pass is checked cycle by cycle.
    initial begin
        repeat (12) @(posedge mclk);
        #1;
        chk("pc", 21'h0, pc);
        nrst = 1'b1;
        step();
        chk("pc", 21'h2, pc);
        chk("wr", 21'h1, mem_wr);
        chk("rd", 21'h1, mem_rd);
        chk("addr", 21'h223, mem_addr);
        chk("wdata", 21'h65, mem_wdata);
        chk("zero", 21'h0, set_zero);
        step();
        chk("wr", 21'h1, mem_wr);
        chk("addr", 21'hf90, mem_addr);
        chk("wdata", 21'h0, mem_wdata);
        chk("zero", 21'h1, set_zero);
        step();
        chk("addr", 21'h15, mem_addr);
        chk("wdata", 21'h74, mem_wdata);
        step();
        chk("wdclr", 21'h1, wd_clear);
        chk("wr", 21'h0, mem_wr);
        step();
        chk("pc", 21'ha, pc);
        step();
        chk("pc", 21'h10, pc);
        step();
        chk("pc", 21'h10, pc);
        chk("wdclr", 21'h0, wd_clear);
        step();
        chk("push", 21'h0, push);
        step();
        chk("push", 21'h1, push);
        chk("tos", 21'h14, return_stack_top);
        chk("pc", 21'h40, pc);
        chk("save", 21'h1, shadow_save);
        chk("wsh", 21'h3c, w_sh);
        chk("fsh", 21'h4, f_sh);
        chk("bsh", 21'h2, b_sh);
        chk("zero", 21'h0, set_zero);
        flags = 8'h08;
        working = 8'hc3;
        // The call's target runs at the very next edge: it is a taken overflow branch.
        step();
        chk("pc", 21'h140, pc);
        chk("push", 21'h0, push);
        step();
        chk("pc", 21'h140, pc);
        step();
        chk("pc", 21'h142, pc);
        step();
        chk("push", 21'h1, push);
        chk("tos", 21'h144, return_stack_top);
        chk("pc", 21'h0, pc);
        chk("save", 21'h0, shadow_save);
        chk("wsh", 21'h3c, w_sh);
        chk("fsh", 21'h4, f_sh);
        // Second pass with the extended set off and no flags set: the low address
        // falls in the access bank and neither branch is taken.
        flags = 8'h00;
        ext_set_en = 1'b0;
        step();
        step();
        step();
        chk("addr", 21'h5, mem_addr);
        chk("rd", 21'h1, mem_rd);
        step();
        step();
        chk("pc", 21'ha, pc);
        step();
        chk("pc", 21'hc, pc);
        test_done();
    end
endmodule // core_instr_exec_subset_test

`default_nettype wire
